// file: include/hiad_pkg.sv
// Purpose: shared constants and types for the host interrupt and address decode block
// Assumes: 8-bit multiplexed host bus sampled on core_clk
// Notes: all offsets are byte addresses on the host bus
package hiad_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and counts
  localparam int unsigned DATA_W = 8;
  localparam int unsigned N_CTRL = 6;
  localparam int unsigned N_CNT_SRC = 7;
  localparam int unsigned N_LINK_SRC = 4;
  localparam int unsigned N_ERRC = 7;
  localparam int unsigned N_STAT_LVL = 5;
  localparam int unsigned MSG_DEPTH = 8;
  localparam int unsigned MSG_AW = 3;

  ////////////////////////////////////////////////////////////////////////////
  // address map
  localparam logic [7:0] CTRL_LO = 8'h00;
  localparam logic [7:0] CTRL_HI = 8'h05;
  localparam logic [7:0] MODE_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] STATUS_INTERRUPT_ENABLE = 8'h02;
  localparam logic [7:0] STAT_LO = 8'h10;
  localparam logic [7:0] STAT_HI = 8'h16;
  localparam logic [7:0] COUNTER_INTERRUPT_STATUS = 8'h11;
  localparam logic [7:0] LINK_INTERRUPT_STATUS = 8'h12;
  localparam logic [7:0] STAT_LVL_BASE = 8'h12;
  localparam logic [7:0] ERRC_LO = 8'h20;
  localparam logic [7:0] ERRC_HI = 8'h26;
  localparam logic [7:0] TXBUF_LO = 8'h30;
  localparam logic [7:0] TXBUF_HI = 8'h37;
  localparam logic [7:0] RXBUF_LO = 8'h40;
  localparam logic [7:0] RXBUF_HI = 8'h47;

  ////////////////////////////////////////////////////////////////////////////
  // fields and reset values
  localparam int unsigned CBIT_LINK_EN_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] ERRC_MAX = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned INIT_MIN_NS = 200;
  localparam int unsigned INIT_MIN_CYC = (INIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic cs;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [7:0] ad;
  } hiad_bus_in_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_READ = 3'b010,
    BUS_WRITE = 3'b100
  } hiad_bus_state_t;

endpackage

// file: design/hiad_msgbuf.sv
// Purpose: small two-port message buffer with registered read data
// Assumes: both ports on core_clk
// Notes: port a wins when both ports write the same word
`timescale 1ns/1ps
`default_nettype none
module hiad_msgbuf
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic a_we,
  input wire logic [hiad_pkg::MSG_AW-1:0] a_addr,
  input wire logic [hiad_pkg::DATA_W-1:0] a_wdata,
  output logic [hiad_pkg::DATA_W-1:0] a_rdata,
  input wire logic b_we,
  input wire logic [hiad_pkg::MSG_AW-1:0] b_addr,
  input wire logic [hiad_pkg::DATA_W-1:0] b_wdata,
  output logic [hiad_pkg::DATA_W-1:0] b_rdata
);

  logic [hiad_pkg::DATA_W-1:0] mem_r [hiad_pkg::MSG_DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (a_we)
    begin
      mem_r[a_addr] <= a_wdata;
    end
    if (b_we && !(a_we && (a_addr == b_addr)))
    begin
      mem_r[b_addr] <= b_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      a_rdata <= '0;
      b_rdata <= '0;
    end
    else
    begin
      a_rdata <= mem_r[a_addr];
      b_rdata <= mem_r[b_addr];
    end
  end

endmodule // hiad_msgbuf
`default_nettype wire

// file: design/hiad_err_cnt.sv
// Purpose: bank of saturating maintenance error counters
// Assumes: increment pulses synchronous to core_clk
// Notes: clear dominates increment
`timescale 1ns/1ps
`default_nettype none
module hiad_err_cnt
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic [hiad_pkg::N_ERRC-1:0] inc,
  output logic [hiad_pkg::N_ERRC*hiad_pkg::DATA_W-1:0] cnt
);

  genvar gi;
  generate
    for (gi = 0; gi < hiad_pkg::N_ERRC; gi++)
    begin : g_cnt
      logic [hiad_pkg::DATA_W-1:0] cnt_r;
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          cnt_r <= '0;
        end
        else if (clr)
        begin
          cnt_r <= '0;
        end
        else if (inc[gi] && (cnt_r != hiad_pkg::ERRC_MAX))
        begin
          // saturate so a wrapped count never looks small
          cnt_r <= cnt_r + 8'h01;
        end
      end
      assign cnt[gi*hiad_pkg::DATA_W +: hiad_pkg::DATA_W] = cnt_r;
    end
  endgenerate

endmodule // hiad_err_cnt
`default_nettype wire

// file: design/hiad_top.sv
// Purpose: host bus slave, address decode and interrupt pins of the framer
// Assumes: bus pins synchronous to core_clk; one idle cycle between ALE and a strobe
// Notes: reads clear the two interrupt status registers
//
// Function
// RULE_01: seven counter causes merge onto the single counter interrupt pin.
// RULE_02: counter pin low while any cause enabled in status_interrupt_enable is set.
// RULE_03: pending counter causes are readable at counter_interrupt_status.
// RULE_04: four link causes merge onto link pin; readable at link_interrupt_status.
// RULE_05: link pin held released while the link interrupt enable bit is clear.
// RULE_06: both interrupt pins are open-drain, drive low only.
// RULE_07: control registers 0x00 to 0x05 latch writes and read back.
// RULE_08: status registers 0x10 to 0x16 are read-only.
// RULE_09: error counters are read-only at 0x20 to 0x26.
// RULE_10: transmit message buffer is eight read/write bytes at 0x30 to 0x37.
// RULE_11: receive message buffer is eight read/write bytes at 0x40 to 0x47.
// RULE_12: accesses are ignored unless chip select is high.
// RULE_13: initialization low clears error counters and blocks host access.
// RULE_14: host uses 8-bit multiplexed bus with ALE, read, write, chip select.
// RULE_15: each pin releases once no enabled cause remains pending.
`timescale 1ns/1ps
`default_nettype none
module hiad_top
(
  input wire logic core_clk,
  input wire logic rst,
  input wire hiad_pkg::hiad_bus_in_t bus_in,
  input wire logic init_n,
  output logic [hiad_pkg::DATA_W-1:0] ad_out,
  output logic ad_oe,
  output logic counter_irq_n_out,
  output logic counter_irq_n_oe,
  output logic link_irq_n_out,
  output logic link_irq_n_oe,
  input wire logic [hiad_pkg::N_CNT_SRC-1:0] cnt_irq_event,
  input wire logic [hiad_pkg::N_LINK_SRC-1:0] link_irq_event,
  input wire logic [hiad_pkg::N_STAT_LVL*hiad_pkg::DATA_W-1:0] status_level,
  input wire logic [hiad_pkg::N_ERRC-1:0] err_event,
  output logic [hiad_pkg::N_CTRL*hiad_pkg::DATA_W-1:0] ctrl_out,
  input wire logic rx_msg_we,
  input wire logic [hiad_pkg::MSG_AW-1:0] rx_msg_addr,
  input wire logic [hiad_pkg::DATA_W-1:0] rx_msg_wdata,
  input wire logic [hiad_pkg::MSG_AW-1:0] tx_msg_addr,
  output logic [hiad_pkg::DATA_W-1:0] tx_msg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  hiad_pkg::hiad_bus_state_t bus_state_r;
  hiad_pkg::hiad_bus_state_t bus_state_nxt;
  logic [7:0] addr_r;
  logic [hiad_pkg::DATA_W-1:0] ctrl_r [hiad_pkg::N_CTRL];
  logic [hiad_pkg::N_CNT_SRC-1:0] cnt_stat_r;
  logic [hiad_pkg::N_LINK_SRC-1:0] link_stat_r;
  logic [hiad_pkg::DATA_W-1:0] ad_out_r;
  logic ad_oe_r;
  logic counter_irq_oe_r;
  logic link_irq_oe_r;
  logic access_ok;
  logic rd_start;
  logic wr_start;
  logic [hiad_pkg::DATA_W-1:0] rd_mux;
  logic [hiad_pkg::N_ERRC*hiad_pkg::DATA_W-1:0] err_cnt;
  logic [hiad_pkg::DATA_W-1:0] txbuf_rdata;
  logic [hiad_pkg::DATA_W-1:0] rxbuf_rdata;
  logic txbuf_we;
  logic rxbuf_we;
  logic clr_cnt_stat;
  logic clr_link_stat;
  logic [7:0] lvl_idx;
  logic [7:0] err_idx;
  logic [hiad_pkg::N_CNT_SRC-1:0] cnt_enable;
  logic link_enable;

  ////////////////////////////////////////////////////////////////////////////
  // bus access qualification

  // init low locks the host out entirely
  assign access_ok = bus_in.cs && init_n; // [RULE_12] [RULE_13]

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_r <= 8'h00;
      bus_state_r <= hiad_pkg::BUS_IDLE;
    end
    else
    begin
      bus_state_r <= bus_state_nxt;
      if (access_ok && bus_in.ale)
      begin
        addr_r <= bus_in.ad; // [RULE_14]
      end
    end
  end

  always_comb
  begin
    bus_state_nxt = bus_state_r;
    rd_start = 1'b0;
    wr_start = 1'b0;
    case (bus_state_r)
      hiad_pkg::BUS_IDLE:
      begin
        if (access_ok && !bus_in.ale && !bus_in.rd_n)
        begin
          bus_state_nxt = hiad_pkg::BUS_READ;
          rd_start = 1'b1;
        end
        else if (access_ok && !bus_in.ale && !bus_in.wr_n)
        begin
          bus_state_nxt = hiad_pkg::BUS_WRITE;
          wr_start = 1'b1; // [RULE_14]
        end
      end
      hiad_pkg::BUS_READ:
      begin
        if (!access_ok || bus_in.rd_n)
        begin
          bus_state_nxt = hiad_pkg::BUS_IDLE;
        end
      end
      hiad_pkg::BUS_WRITE:
      begin
        if (!access_ok || bus_in.wr_n)
        begin
          bus_state_nxt = hiad_pkg::BUS_IDLE;
        end
      end
      default:
      begin
        bus_state_nxt = hiad_pkg::BUS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  genvar gi;
  generate
    for (gi = 0; gi < hiad_pkg::N_CTRL; gi++)
    begin : g_ctrl
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          ctrl_r[gi] <= hiad_pkg::CTRL_RESET;
          ctrl_out[gi*hiad_pkg::DATA_W +: hiad_pkg::DATA_W] <= hiad_pkg::CTRL_RESET;
        end
        else
        begin
          if (wr_start && (addr_r == (hiad_pkg::CTRL_LO + 8'(gi))))
          begin
            ctrl_r[gi] <= bus_in.ad; // [RULE_07]
          end
          ctrl_out[gi*hiad_pkg::DATA_W +: hiad_pkg::DATA_W] <= ctrl_r[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, cleared by reading

  assign clr_cnt_stat = rd_start && (addr_r == hiad_pkg::COUNTER_INTERRUPT_STATUS);
  assign clr_link_stat = rd_start && (addr_r == hiad_pkg::LINK_INTERRUPT_STATUS);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_stat_r <= '0;
      link_stat_r <= '0;
    end
    else
    begin
      // a new event in the clearing cycle survives the clear
      cnt_stat_r <= (clr_cnt_stat ? '0 : cnt_stat_r) | cnt_irq_event; // [RULE_03]
      link_stat_r <= (clr_link_stat ? '0 : link_stat_r) | link_irq_event; // [RULE_04]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain interrupt pins

  assign cnt_enable = ctrl_r[3'(hiad_pkg::STATUS_INTERRUPT_ENABLE)][hiad_pkg::N_CNT_SRC-1:0];
  assign link_enable = ctrl_r[3'(hiad_pkg::MODE_CONTROL_ZERO)][hiad_pkg::CBIT_LINK_EN_BIT];

  // pins only ever pull low, so they can share one wire
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      counter_irq_oe_r <= 1'b0;
      link_irq_oe_r <= 1'b0;
      counter_irq_n_out <= 1'b0;
      link_irq_n_out <= 1'b0;
    end
    else
    begin
      counter_irq_oe_r <= |(cnt_stat_r & cnt_enable); // [RULE_01] [RULE_02] [RULE_15]
      link_irq_oe_r <= link_enable && (|link_stat_r); // [RULE_05] [RULE_15]
      counter_irq_n_out <= 1'b0; // [RULE_06]
      link_irq_n_out <= 1'b0; // [RULE_06]
    end
  end

  assign counter_irq_n_oe = counter_irq_oe_r;
  assign link_irq_n_oe = link_irq_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // error counters and message buffers

  hiad_err_cnt u_err_cnt
  (
    .core_clk(core_clk),
    .rst(rst),
    .clr(!init_n), // [RULE_13]
    .inc(err_event),
    .cnt(err_cnt)
  );

  assign txbuf_we = wr_start && in_range(addr_r, hiad_pkg::TXBUF_LO, hiad_pkg::TXBUF_HI);
  assign rxbuf_we = wr_start && in_range(addr_r, hiad_pkg::RXBUF_LO, hiad_pkg::RXBUF_HI);

  hiad_msgbuf u_txbuf
  (
    .core_clk(core_clk),
    .rst(rst),
    .a_we(txbuf_we), // [RULE_10]
    .a_addr(addr_r[hiad_pkg::MSG_AW-1:0]),
    .a_wdata(bus_in.ad),
    .a_rdata(txbuf_rdata),
    .b_we(1'b0),
    .b_addr(tx_msg_addr),
    .b_wdata(8'h00),
    .b_rdata(tx_msg_rdata)
  );

  // the receiver fills it; host writes win on a same-word collision
  hiad_msgbuf u_rxbuf
  (
    .core_clk(core_clk),
    .rst(rst),
    .a_we(rxbuf_we), // [RULE_11]
    .a_addr(addr_r[hiad_pkg::MSG_AW-1:0]),
    .a_wdata(bus_in.ad),
    .a_rdata(rxbuf_rdata),
    .b_we(rx_msg_we),
    .b_addr(rx_msg_addr),
    .b_wdata(rx_msg_wdata),
    .b_rdata()
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path

  assign lvl_idx = (addr_r == hiad_pkg::STAT_LO) ? 8'h00 : (addr_r - hiad_pkg::STAT_LVL_BASE);
  assign err_idx = addr_r - hiad_pkg::ERRC_LO;

  // status and counters have no write path at all
  always_comb
  begin
    rd_mux = hiad_pkg::UNMAPPED_READ;
    if (in_range(addr_r, hiad_pkg::CTRL_LO, hiad_pkg::CTRL_HI))
    begin
      rd_mux = ctrl_r[3'(addr_r - hiad_pkg::CTRL_LO)]; // [RULE_07]
    end
    else if (addr_r == hiad_pkg::COUNTER_INTERRUPT_STATUS)
    begin
      rd_mux = {1'b0, cnt_stat_r}; // [RULE_03]
    end
    else if (addr_r == hiad_pkg::LINK_INTERRUPT_STATUS)
    begin
      rd_mux = {4'h0, link_stat_r}; // [RULE_04]
    end
    else if (in_range(addr_r, hiad_pkg::STAT_LO, hiad_pkg::STAT_HI))
    begin
      rd_mux = status_level[lvl_idx[2:0]*hiad_pkg::DATA_W +: hiad_pkg::DATA_W]; // [RULE_08]
    end
    else if (in_range(addr_r, hiad_pkg::ERRC_LO, hiad_pkg::ERRC_HI))
    begin
      rd_mux = err_cnt[err_idx[2:0]*hiad_pkg::DATA_W +: hiad_pkg::DATA_W]; // [RULE_09]
    end
    else if (in_range(addr_r, hiad_pkg::TXBUF_LO, hiad_pkg::TXBUF_HI))
    begin
      rd_mux = txbuf_rdata; // [RULE_10]
    end
    else if (in_range(addr_r, hiad_pkg::RXBUF_LO, hiad_pkg::RXBUF_HI))
    begin
      rd_mux = rxbuf_rdata; // [RULE_11]
    end
  end

  // data is captured once per strobe so a read-clear cannot change it mid-read
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ad_out_r <= 8'h00;
      ad_oe_r <= 1'b0;
    end
    else
    begin
      if (rd_start)
      begin
        ad_out_r <= rd_mux;
      end
      ad_oe_r <= rd_start || // [RULE_12]
                 ((bus_state_r == hiad_pkg::BUS_READ) && (bus_state_nxt == hiad_pkg::BUS_READ));
    end
  end

  assign ad_out = ad_out_r;
  assign ad_oe = ad_oe_r;

endmodule // hiad_top
`default_nettype wire

// file: verif/hiad_assertions.sv
// Purpose: bus and interrupt pin checks on hiad_top
// Assumes: bound inside hiad_top, one clock domain
// Notes: pins judged by their output enables
`timescale 1ns/1ps
`default_nettype none
module hiad_assertions
(
  input wire logic core_clk,
  input wire logic rst,
  input wire hiad_pkg::hiad_bus_in_t bus_in,
  input wire logic init_n,
  input wire logic ad_oe,
  input wire logic counter_irq_n_out,
  input wire logic counter_irq_n_oe,
  input wire logic link_irq_n_out,
  input wire logic link_irq_n_oe,
  input wire logic [hiad_pkg::N_CNT_SRC-1:0] cnt_irq_event,
  input wire logic [hiad_pkg::N_LINK_SRC-1:0] link_irq_event,
  input wire logic [hiad_pkg::N_CTRL*hiad_pkg::DATA_W-1:0] ctrl_out
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_pins_drain_only: assert property (!counter_irq_n_out && !link_irq_n_out)
    else $error("interrupt pin value not low");
  a_cnt_masked: assert property (ctrl_out[22:16] == 7'h00
    |-> !counter_irq_n_oe)
    else $error("counter pin active with all causes masked");
  // mask must settle a cycle before the event, else ctrl_out lags
  a_cnt_raise: assert property ((cnt_irq_event & ctrl_out[22:16]) != 7'h00
    |-> ##[1:2] counter_irq_n_oe)
    else $error("enabled counter cause did not pull pin");
  a_link_gated: assert property (!ctrl_out[0] |-> !link_irq_n_oe)
    else $error("link pin active while disabled");
  a_link_raise: assert property (link_irq_event != 4'h0 && ctrl_out[0]
    |-> ##[1:2] link_irq_n_oe)
    else $error("link cause did not pull pin");
  a_read_answer: assert property ($fell(bus_in.rd_n) && bus_in.cs && init_n
    && !bus_in.ale |=> ad_oe)
    else $error("read not answered next cycle");
  a_rd_release: assert property (ad_oe && bus_in.rd_n |=> !ad_oe)
    else $error("bus driven after read strobe");
  a_cs_ignore: assert property (!bus_in.cs |=> !ad_oe)
    else $error("bus driven while deselected");
  a_init_block: assert property (!init_n |=> !ad_oe)
    else $error("bus driven during init");
  a_ctrl_written: assert property (!$stable(ctrl_out)
    |-> $past(bus_in.cs && init_n && !bus_in.wr_n, 2))
    else $error("control changed without a write");
  c_cnt_pin: cover property (!counter_irq_n_oe ##1 counter_irq_n_oe);
  c_link_pin: cover property (!link_irq_n_oe ##1 link_irq_n_oe);
  c_read: cover property (!ad_oe ##1 ad_oe);
endmodule // hiad_assertions
`default_nettype wire

// file: verif/hiad_host_model.sv
// Purpose: host processor on the multiplexed bus
// Assumes: one access at a time, driven 1 ns after core_clk rises
// Notes: a released AD bus shows the inverse of the last host value
`timescale 1ns/1ps
`default_nettype none
module hiad_host_model
(
  input wire logic core_clk,
  input wire logic [hiad_pkg::DATA_W-1:0] ad_out,
  input wire logic ad_oe,
  output var hiad_pkg::hiad_bus_in_t bus
);
  logic cs = 1'b0;
  logic ale = 1'b0;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic hoe = 1'b0;
  logic [7:0] had = 8'h00;
  // no pull on AD, so a floating bus must not look like old data
  assign bus = {cs, ale, rd_n, wr_n, ad_oe ? ad_out : (hoe ? had : ~had)};
  ////////////////////////////////////////
  // select held only around own accesses
  task automatic addr_phase(input logic [7:0] a, input logic sel);
    @(posedge core_clk);
    #1;
    cs = sel;
    ale = 1'b1;
    hoe = 1'b1;
    had = a;
    @(posedge core_clk);
    #1;
    ale = 1'b0;
  endtask
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic sel);
    addr_phase(a, sel);
    @(posedge core_clk);
    #1;
    wr_n = 1'b0;
    had = d;
    @(posedge core_clk);
    #1;
    wr_n = 1'b1;
    hoe = 1'b0;
    cs = 1'b0;
  endtask
  // causes are found by reading status back
  task automatic bus_read(input logic [7:0] a, input logic sel, output logic [7:0] d,
                          output logic got);
    addr_phase(a, sel);
    @(posedge core_clk);
    #1;
    rd_n = 1'b0;
    hoe = 1'b0;
    got = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 4 && !got; i++)
    begin
      @(posedge core_clk);
      if (ad_oe === 1'b1)
      begin
        got = 1'b1;
        d = bus.ad;
      end
    end
    #1;
    rd_n = 1'b1;
    cs = 1'b0;
  endtask
endmodule // hiad_host_model
`default_nettype wire

// file: verif/testbench.sv
// Purpose: self-checking bench for hiad_top
// Assumes: host model drives the bus, bench drives the framer side
// Notes: interrupt pins read through a pull-up
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic init_n = 1'b1;
  logic [6:0] cnt_irq_event = 7'h00;
  logic [3:0] link_irq_event = 4'h0;
  logic [39:0] status_level = 40'h5AC3_C3C3_E1;
  logic [6:0] err_event = 7'h00;
  logic rx_msg_we = 1'b0;
  logic [2:0] rx_msg_addr = 3'h0;
  logic [7:0] rx_msg_wdata = 8'h00;
  logic [2:0] tx_msg_addr = 3'h0;
  hiad_pkg::hiad_bus_in_t bus_in;
  logic [7:0] ad_out, tx_msg_rdata, d;
  logic ad_oe, cnt_oe, cnt_o, link_oe, link_o, got;
  logic [47:0] ctrl_out;
  wire logic cnt_pin;
  wire logic link_pin;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [47:0] ctrl_exp = 48'hC33C_A57F_5AFE;
  // address, write value, expected read
  logic [23:0] rows [16] = '{24'h00FE_FE, 24'h015A_5A, 24'h027F_7F, 24'h03A5_A5,
    24'h043C_3C, 24'h05C3_C3, 24'h10FF_E1, 24'h1600_5A, 24'h20FF_00, 24'h2612_00,
    24'h3011_11, 24'h3777_77, 24'h4022_22, 24'h4788_88, 24'h0899_00, 24'h1166_00};
  assign cnt_pin = cnt_oe ? cnt_o : 1'b1;
  assign link_pin = link_oe ? link_o : 1'b1;
  always #10 core_clk = ~core_clk;
  hiad_top i_dut (.core_clk(core_clk), .rst(rst), .bus_in(bus_in), .init_n(init_n),
    .ad_out(ad_out), .ad_oe(ad_oe), .counter_irq_n_out(cnt_o), .counter_irq_n_oe(cnt_oe),
    .link_irq_n_out(link_o), .link_irq_n_oe(link_oe), .cnt_irq_event(cnt_irq_event),
    .link_irq_event(link_irq_event), .status_level(status_level), .err_event(err_event),
    .ctrl_out(ctrl_out), .rx_msg_we(rx_msg_we), .rx_msg_addr(rx_msg_addr),
    .rx_msg_wdata(rx_msg_wdata), .tx_msg_addr(tx_msg_addr), .tx_msg_rdata(tx_msg_rdata));
  hiad_host_model i_host (.core_clk(core_clk), .ad_out(ad_out), .ad_oe(ad_oe), .bus(bus_in));
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_host.bus_read(a, 1'b1, d, got);
    chk1("answer", 1'b1, got);
    chk8($sformatf("reg %h", a), e, d);
  endtask
  task automatic pulse(input logic [6:0] c, input logic [3:0] l, input logic [6:0] e);
    @(posedge core_clk);
    #1;
    cnt_irq_event = c;
    link_irq_event = l;
    err_event = e;
    @(posedge core_clk);
    #1;
    cnt_irq_event = 7'h00;
    link_irq_event = 4'h0;
    err_event = 7'h00;
  endtask
  // generous: the sequence needs under a thousand cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    tick(3);
    rst = 1'b0;
    foreach (rows[i])
    begin
      i_host.bus_write(rows[i][23:16], rows[i][15:8], 1'b1);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    for (int i = 0; i < 6; i++)
      chk8("ctrl_out", ctrl_exp[8*i+:8], ctrl_out[8*i+:8]);
    tx_msg_addr = 3'h7;
    tick(2);
    chk8("tx_msg_rdata", 8'h77, tx_msg_rdata);
    rx_msg_we = 1'b1;
    rx_msg_addr = 3'h2;
    rx_msg_wdata = 8'h6B;
    tick(1);
    rx_msg_we = 1'b0;
    rd(8'h42, 8'h6B);
    i_host.bus_write(8'h01, 8'h00, 1'b0);
    i_host.bus_read(8'h01, 1'b0, d, got);
    chk1("answer", 1'b0, got);
    rd(8'h01, 8'h5A);
    repeat (3) pulse(7'h00, 4'h0, 7'h41);
    rd(8'h20, 8'h03);
    rd(8'h26, 8'h03);
    init_n = 1'b0;
    i_host.bus_read(8'h20, 1'b1, d, got);
    chk1("answer", 1'b0, got);
    i_host.bus_write(8'h01, 8'h00, 1'b1);
    init_n = 1'b1;
    rd(8'h20, 8'h00);
    rd(8'h01, 8'h5A);
    chk1("counter pin", 1'b1, cnt_pin);
    for (int i = 0; i < 7; i++)
    begin
      i_host.bus_write(8'h02, 8'h01 << i, 1'b1);
      pulse(7'h01 << i, 4'h0, 7'h00);
      tick(2);
      chk1("counter pin", 1'b0, cnt_pin);
      rd(8'h11, 8'h01 << i);
      tick(2);
      chk1("counter pin", 1'b1, cnt_pin);
    end
    i_host.bus_write(8'h02, 8'h3F, 1'b1);
    pulse(7'h40, 4'h0, 7'h00);
    tick(2);
    chk1("counter pin", 1'b1, cnt_pin);
    i_host.bus_write(8'h02, 8'h7F, 1'b1);
    tick(2);
    chk1("counter pin", 1'b0, cnt_pin);
    i_host.bus_write(8'h02, 8'h00, 1'b1);
    tick(2);
    chk1("counter pin", 1'b1, cnt_pin);
    i_host.bus_write(8'h02, 8'h7F, 1'b1);
    rd(8'h11, 8'h40);
    tick(2);
    chk1("counter pin", 1'b1, cnt_pin);
    i_host.bus_write(8'h00, 8'h00, 1'b1);
    pulse(7'h00, 4'h4, 7'h00);
    tick(2);
    chk1("link pin", 1'b1, link_pin);
    rd(8'h12, 8'h04);
    i_host.bus_write(8'h00, 8'h01, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      pulse(7'h00, 4'h1 << i, 7'h00);
      tick(2);
      chk1("link pin", 1'b0, link_pin);
      rd(8'h12, 8'h01 << i);
      tick(2);
      chk1("link pin", 1'b1, link_pin);
    end
    pulse(7'h01, 4'h0, 7'h00);
    rst = 1'b1;
    tick(3);
    chk1("counter pin", 1'b1, cnt_pin);
    chk8("ctrl_out", 8'h00, ctrl_out[7:0]);
    rst = 1'b0;
    rd(8'h02, hiad_pkg::CTRL_RESET);
    rd(8'h11, 8'h00);
    report_and_stop();
  end
endmodule // testbench
bind hiad_top hiad_assertions i_chk (.core_clk(core_clk), .rst(rst), .bus_in(bus_in),
  .init_n(init_n), .ad_oe(ad_oe), .counter_irq_n_out(counter_irq_n_out),
  .counter_irq_n_oe(counter_irq_n_oe), .link_irq_n_out(link_irq_n_out),
  .link_irq_n_oe(link_irq_n_oe), .cnt_irq_event(cnt_irq_event),
  .link_irq_event(link_irq_event), .ctrl_out(ctrl_out));
`default_nettype wire
